// ===== design/lbq_bias_startup.sv
// laser bias startup ramp, binary search, quick-trip and loss-of-signal
// Function
// - hot step at or above boundary, cold below
// - startup at reset and each disable pulse
// - add step plus one until monitor exceeds
// - then binary search the bias word
// - step over ceiling: skip, start search
// - bias-max alarm enabled after search ends
// - high trip code is setpoint plus offset
// - high trip sum saturates at 0xff
// - high alarm when monitor above high code
// - low trip code is setpoint minus offset
// - low trip difference clamps at zero
// - low alarm when monitor below low code
// - signal below low threshold sets loss-low
// - loss persists until above high threshold
// - above high: clear low, set high
// - both loss bits zero at power-on
// - comparator starts on the low threshold
// - 3-bit ranging field, default zero
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "lbq_defines.svh"

module lbq_bias_startup (
    input wire logic SYS_CLK, // system clock
    input wire logic RST, // synchronous reset
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb enable
    input wire logic PWRITE, // apb direction
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error
    input wire logic [7:0] TEMP_INDEX, // temperature index
    input wire logic [7:0] POWER_SETPOINT_CODE, // recalled setpoint
    input wire logic [7:0] POWER_MONITOR_INPUT, // power monitor code
    input wire logic [7:0] SIGNAL_STRENGTH, // received strength code
    input wire logic TX_DISABLE, // transmit disable pin
    output logic [8:0] BIAS_WORD, // laser bias word
    output logic STARTUP_DONE, // search finished
    output logic BIAS_MAX_ALARM, // bias above ceiling
    output logic HIGH_POWER_ALARM, // transmit power high
    output logic LOW_POWER_ALARM, // transmit power low
    output logic SIGNAL_LOSS_LOW_ALARM, // loss-of-signal low
    output logic SIGNAL_LOSS_HIGH_ALARM, // loss-of-signal high
    output logic [7:0] HIGH_TRIP_CODE, // high trip threshold
    output logic [7:0] LOW_TRIP_CODE, // low trip threshold
    output logic [2:0] POWER_LOOP_RANGING // monitor full scale
);

    localparam int SW = 17;
    localparam logic [7:0] SETTLE = 8'(`LBQ_SETTLE_CYC);

    // pin synchroniser, three stages
    logic [SW-1:0] sync1;
    logic [SW-1:0] sync2;
    logic [SW-1:0] sync3;
    logic [SW-1:0] pins;
    logic [SW-1:0] next_pins;
    wire [SW-1:0] raw_pins = {TX_DISABLE, SIGNAL_STRENGTH,
                              POWER_MONITOR_INPUT};

    // a bit changes once the second and third stages agree
    genvar g;
    generate
        for (g = 0; g < SW; g++)
        begin : g_filt
            assign next_pins[g] = (sync2[g] == sync3[g]) ?
                                  sync3[g] : pins[g];
        end
    endgenerate

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            pins <= '0;
        end
        else
        begin
            sync1 <= raw_pins;
            sync2 <= sync1;
            sync3 <= sync2;
            pins <= next_pins;
        end
    end

    wire [7:0] mon = pins[7:0];
    wire [7:0] rssi = pins[15:8];
    wire txd = pins[16];
    logic txd_d;

    // registers
    logic [7:0] ranging;
    logic [7:0] hot_step;
    logic [7:0] cold_step;
    logic [7:0] hi_ofs;
    logic [7:0] lo_ofs;
    logic [7:0] signal_loss_high_alarm_thr;
    logic [7:0] signal_loss_low_alarm_thr;
    logic [7:0] step_ti;
    logic [7:0] ceiling;

    // apb decode
    wire [9:0] idx = PADDR[11:2];
    wire aligned = (PADDR[1:0] == 2'b00);
    wire hit_rng = aligned && idx == {2'b00, `LBQ_IDX_RANGING};
    wire hit_hst = aligned && idx == {2'b00, `LBQ_IDX_HOT_STEP};
    wire hit_cst = aligned && idx == {2'b00, `LBQ_IDX_COLD_STEP};
    wire hit_hof = aligned && idx == {2'b00, `LBQ_IDX_HI_OFS};
    wire hit_lof = aligned && idx == {2'b00, `LBQ_IDX_LO_OFS};
    wire hit_lhi = aligned && idx == {2'b00, `LBQ_IDX_SIGNAL_LOSS_HIGH_ALARM};
    wire hit_llo = aligned && idx == {2'b00, `LBQ_IDX_SIGNAL_LOSS_LOW_ALARM};
    wire hit_sti = aligned && idx == {2'b00, `LBQ_IDX_STEP_TI};
    wire hit_spt = aligned && idx == {2'b00, `LBQ_IDX_SETPOINT};
    wire hit_sta = aligned && idx == {2'b00, `LBQ_IDX_STATUS};
    wire hit_cei = aligned && idx == {2'b00, `LBQ_IDX_CEILING};
    wire hit_any = hit_rng | hit_hst | hit_cst | hit_hof | hit_lof |
                   hit_lhi | hit_llo | hit_sti | hit_spt | hit_sta |
                   hit_cei;
    wire access = PSEL && PENABLE && !PREADY;
    wire wr = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;

    lbq_pkg::lbq_state_t state;
    lbq_pkg::lbq_bias_t bias;
    lbq_pkg::lbq_bias_t result;
    lbq_pkg::lbq_bias_t trial_bit;
    logic [7:0] settle_cnt;
    logic bmax_en;

    wire [31:0] status_word = {16'h0000,
                               1'b0,
                               SIGNAL_LOSS_HIGH_ALARM,
                               SIGNAL_LOSS_LOW_ALARM,
                               LOW_POWER_ALARM,
                               HIGH_POWER_ALARM,
                               BIAS_MAX_ALARM,
                               STARTUP_DONE,
                               bias};

    wire [7:0] rd_byte = hit_rng ? ranging :
                         hit_hst ? hot_step :
                         hit_cst ? cold_step :
                         hit_hof ? hi_ofs :
                         hit_lof ? lo_ofs :
                         hit_lhi ? signal_loss_high_alarm_thr :
                         hit_llo ? signal_loss_low_alarm_thr :
                         hit_sti ? step_ti :
                         hit_spt ? POWER_SETPOINT_CODE :
                         hit_cei ? ceiling : 8'h00;
    wire [31:0] rd_word = hit_sta ? status_word : {24'h000000, rd_byte};

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end
        else
        begin
            PREADY <= access;
            PSLVERR <= access && !hit_any;
            PRDATA <= (access && !PWRITE) ? rd_word : 32'h00000000;
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            ranging <= `LBQ_RST_BYTE;
            hot_step <= `LBQ_RST_BYTE;
            cold_step <= `LBQ_RST_BYTE;
            hi_ofs <= `LBQ_RST_BYTE;
            lo_ofs <= `LBQ_RST_BYTE;
            signal_loss_high_alarm_thr <= `LBQ_RST_BYTE;
            signal_loss_low_alarm_thr <= `LBQ_RST_BYTE;
            step_ti <= `LBQ_RST_BYTE;
            ceiling <= `LBQ_RST_CEILING;
        end
        else if (wr)
        begin
            if (hit_rng)
                ranging <= {5'b00000, PWDATA[2:0]};
            if (hit_hst)
                hot_step <= PWDATA[7:0];
            if (hit_cst)
                cold_step <= PWDATA[7:0];
            if (hit_hof)
                hi_ofs <= PWDATA[7:0];
            if (hit_lof)
                lo_ofs <= PWDATA[7:0];
            if (hit_lhi)
                signal_loss_high_alarm_thr <= PWDATA[7:0];
            if (hit_llo)
                signal_loss_low_alarm_thr <= PWDATA[7:0];
            if (hit_sti)
                step_ti <= PWDATA[7:0];
            if (hit_cei)
                ceiling <= PWDATA[7:0];
        end
    end

    wire [7:0] step_sel = (TEMP_INDEX >= step_ti) ? hot_step : cold_step;
    // step register holds bits 8:1, plus one
    wire [9:0] ramp_sum = {1'b0, bias} + {1'b0, step_sel, 1'b1};
    wire [9:0] ceil_word = {1'b0, ceiling, 1'b1};
    wire mon_over = mon > POWER_SETPOINT_CODE;
    wire [8:0] trial_val = result | trial_bit;
    // end of a disable pulse restarts
    wire txd_pulse = txd_d && !txd;

    // startup sequencer
    always_ff @(posedge SYS_CLK)
    begin
        if (RST || txd_pulse)
        begin
            state <= lbq_pkg::ST_RAMP;
            bias <= 9'h000;
            result <= 9'h000;
            trial_bit <= 9'h100;
            settle_cnt <= 8'h00;
            bmax_en <= 1'b0;
        end
        else
        begin
            case (state)
                lbq_pkg::ST_RAMP:
                begin
                    if (mon_over)
                        state <= lbq_pkg::ST_TRIAL;
                    else if (ramp_sum > ceil_word)
                        state <= lbq_pkg::ST_TRIAL;
                    else
                    begin
                        bias <= ramp_sum[8:0];
                        settle_cnt <= SETTLE;
                        state <= lbq_pkg::ST_RAMP_WAIT;
                    end
                end
                lbq_pkg::ST_RAMP_WAIT:
                begin
                    if (settle_cnt == 8'h00)
                        state <= lbq_pkg::ST_RAMP;
                    else
                        settle_cnt <= settle_cnt - 8'h01;
                end
                lbq_pkg::ST_TRIAL:
                begin
                    bias <= trial_val;
                    settle_cnt <= SETTLE;
                    state <= lbq_pkg::ST_TRIAL_WAIT;
                end
                lbq_pkg::ST_TRIAL_WAIT:
                begin
                    if (settle_cnt != 8'h00)
                        settle_cnt <= settle_cnt - 8'h01;
                    else
                    begin
                        // keep bit if power still short
                        if (!mon_over && {1'b0, trial_val} <= ceil_word)
                            result <= trial_val;
                        trial_bit <= trial_bit >> 1;
                        if (trial_bit == 9'h001)
                        begin
                            bias <= (!mon_over &&
                                     {1'b0, trial_val} <= ceil_word) ?
                                    trial_val : result;
                            state <= lbq_pkg::ST_RUN;
                            bmax_en <= 1'b1;
                        end
                        else
                            state <= lbq_pkg::ST_TRIAL;
                    end
                end
                lbq_pkg::ST_RUN:
                    state <= lbq_pkg::ST_RUN;
                default:
                    state <= lbq_pkg::ST_RAMP;
            endcase
        end
    end

    wire [8:0] hi_sum = {1'b0, POWER_SETPOINT_CODE} + {1'b0, hi_ofs};
    wire [7:0] hi_code = hi_sum[8] ? `LBQ_BYTE_MAX : hi_sum[7:0];
    // low trip code, clamped at zero
    wire [7:0] lo_code = (lo_ofs > POWER_SETPOINT_CODE) ? `LBQ_BYTE_MIN :
                         8'(POWER_SETPOINT_CODE - lo_ofs);

    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            txd_d <= 1'b0;
            BIAS_WORD <= 9'h000;
            STARTUP_DONE <= 1'b0;
            BIAS_MAX_ALARM <= 1'b0;
            HIGH_POWER_ALARM <= 1'b0;
            LOW_POWER_ALARM <= 1'b0;
            HIGH_TRIP_CODE <= 8'h00;
            LOW_TRIP_CODE <= 8'h00;
            POWER_LOOP_RANGING <= 3'h0;
        end
        else
        begin
            txd_d <= txd;
            BIAS_WORD <= bias;
            STARTUP_DONE <= state == lbq_pkg::ST_RUN;
            BIAS_MAX_ALARM <= bmax_en && ({1'b0, bias} > ceil_word);
            HIGH_TRIP_CODE <= hi_code;
            LOW_TRIP_CODE <= lo_code;
            HIGH_POWER_ALARM <= mon > hi_code;
            LOW_POWER_ALARM <= mon < lo_code;
            POWER_LOOP_RANGING <= ranging[`LBQ_RANGING_MSB:`LBQ_RANGING_LSB];
        end
    end

    // loss-of-signal hysteresis comparator
    always_ff @(posedge SYS_CLK)
    begin
        if (RST)
        begin
            SIGNAL_LOSS_LOW_ALARM <= 1'b0;
            SIGNAL_LOSS_HIGH_ALARM <= 1'b0;
        end
        else if (!SIGNAL_LOSS_LOW_ALARM)
        begin
            if (rssi < signal_loss_low_alarm_thr)
            begin
                SIGNAL_LOSS_LOW_ALARM <= 1'b1;
                SIGNAL_LOSS_HIGH_ALARM <= 1'b0;
            end
        end
        else if (rssi > signal_loss_high_alarm_thr)
        begin
            SIGNAL_LOSS_LOW_ALARM <= 1'b0;
            SIGNAL_LOSS_HIGH_ALARM <= 1'b1;
        end
    end

endmodule : lbq_bias_startup

// ===== design/lbq_defines.svh
// offsets, field positions, reset values and timing counts
`ifndef LBQ_DEFINES_SVH
`define LBQ_DEFINES_SVH

// register indices; byte address is four times the index
`define LBQ_IDX_RANGING 8'hb9
`define LBQ_IDX_HOT_STEP 8'hba
`define LBQ_IDX_COLD_STEP 8'hbb
`define LBQ_IDX_HI_OFS 8'hbc
`define LBQ_IDX_LO_OFS 8'hbd
`define LBQ_IDX_SIGNAL_LOSS_HIGH_ALARM 8'hbe
`define LBQ_IDX_SIGNAL_LOSS_LOW_ALARM 8'hbf
`define LBQ_IDX_STEP_TI 8'hc5
`define LBQ_IDX_SETPOINT 8'hd0
`define LBQ_IDX_STATUS 8'hd1
`define LBQ_IDX_CEILING 8'hee

`define LBQ_RST_BYTE 8'h00
`define LBQ_RST_CEILING 8'hff
`define LBQ_RANGING_LSB 0
`define LBQ_RANGING_MSB 2
`define LBQ_BYTE_MAX 8'hff
`define LBQ_BYTE_MIN 8'h00

// status register fields
`define LBQ_ST_DONE 9
`define LBQ_ST_BMAX 10
`define LBQ_ST_HIPWR 11
`define LBQ_ST_LOPWR 12
`define LBQ_ST_LOSLO 13
`define LBQ_ST_LOSHI 14
`define LBQ_ST_STATE 15

// bias settle time after each bias change
`define LBQ_CLK_PERIOD_NS 8
`define LBQ_SETTLE_NS 1000
`define LBQ_SETTLE_CYC \
    ((`LBQ_SETTLE_NS + `LBQ_CLK_PERIOD_NS - 1) / `LBQ_CLK_PERIOD_NS)

`endif

// ===== design/lbq_pkg.sv
// types of the laser bias startup and quick-trip block
package lbq_pkg;

    typedef enum logic [2:0] {
        ST_RAMP,
        ST_RAMP_WAIT,
        ST_TRIAL,
        ST_TRIAL_WAIT,
        ST_RUN
    } lbq_state_t;

    typedef logic [8:0] lbq_bias_t;

endpackage : lbq_pkg

// ===== tb/lbq_bias_checker.sv
// port assertions for the bias startup block
`timescale 1ns/1ps
module lbq_bias_checker (
    input wire logic SYS_CLK, // clock
    input wire logic RST, // reset
    input wire logic PSEL, // apb select
    input wire logic PWRITE, // apb direction
    input wire logic [7:0] POWER_SETPOINT_CODE, // setpoint
    input wire logic [8:0] BIAS_WORD, // bias word
    input wire logic STARTUP_DONE, // search done
    input wire logic BIAS_MAX_ALARM, // bias over ceiling
    input wire logic HIGH_POWER_ALARM, // power high
    input wire logic LOW_POWER_ALARM, // power low
    input wire logic SIGNAL_LOSS_LOW_ALARM, // loss low
    input wire logic SIGNAL_LOSS_HIGH_ALARM, // loss high
    input wire logic [7:0] HIGH_TRIP_CODE, // high trip
    input wire logic [7:0] LOW_TRIP_CODE, // low trip
    input wire logic [2:0] POWER_LOOP_RANGING // ranging
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);
    chk_hi_floor: assert property (
        !$past(RST) && !$past(RST, 2) &&
        $past(POWER_SETPOINT_CODE, 2) == POWER_SETPOINT_CODE
        |-> HIGH_TRIP_CODE >= POWER_SETPOINT_CODE)
        else $error("high trip code below setpoint");
    chk_lo_ceil: assert property (
        !$past(RST) && !$past(RST, 2) &&
        $past(POWER_SETPOINT_CODE, 2) == POWER_SETPOINT_CODE
        |-> LOW_TRIP_CODE <= POWER_SETPOINT_CODE)
        else $error("low trip code above setpoint");
    chk_pwr_excl: assert property (
        $stable(HIGH_TRIP_CODE) && $stable(LOW_TRIP_CODE) &&
        HIGH_TRIP_CODE >= LOW_TRIP_CODE
        |-> !(HIGH_POWER_ALARM && LOW_POWER_ALARM))
        else $error("power high and low together");
    chk_los_excl: assert property (
        !(SIGNAL_LOSS_LOW_ALARM && SIGNAL_LOSS_HIGH_ALARM))
        else $error("both loss alarms set");
    chk_hi_after_lo: assert property (
        $rose(SIGNAL_LOSS_HIGH_ALARM) |-> $past(SIGNAL_LOSS_LOW_ALARM))
        else $error("loss high set without loss low");
    chk_los_reset: assert property (
        $fell(RST) |-> !SIGNAL_LOSS_LOW_ALARM && !SIGNAL_LOSS_HIGH_ALARM)
        else $error("loss alarm set after reset");
    chk_bmax_armed: assert property (
        BIAS_MAX_ALARM |-> STARTUP_DONE || $past(STARTUP_DONE))
        else $error("bias max alarm during startup");
    chk_run_hold: assert property (
        STARTUP_DONE [*3] |-> $stable(BIAS_WORD))
        else $error("bias moved after search end");
    chk_range_write: assert property (
        $changed(POWER_LOOP_RANGING) |-> $past(PSEL && PWRITE, 2))
        else $error("ranging changed without a write");
    cover property ($rose(STARTUP_DONE));
    cover property ($rose(SIGNAL_LOSS_HIGH_ALARM));
    cover property ($rose(BIAS_MAX_ALARM));
endmodule : lbq_bias_checker

bind lbq_bias_startup lbq_bias_checker chk_u (
    .SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL), .PWRITE(PWRITE),
    .POWER_SETPOINT_CODE(POWER_SETPOINT_CODE), .BIAS_WORD(BIAS_WORD),
    .STARTUP_DONE(STARTUP_DONE), .BIAS_MAX_ALARM(BIAS_MAX_ALARM),
    .HIGH_POWER_ALARM(HIGH_POWER_ALARM), .LOW_POWER_ALARM(LOW_POWER_ALARM),
    .SIGNAL_LOSS_LOW_ALARM(SIGNAL_LOSS_LOW_ALARM),
    .SIGNAL_LOSS_HIGH_ALARM(SIGNAL_LOSS_HIGH_ALARM),
    .HIGH_TRIP_CODE(HIGH_TRIP_CODE), .LOW_TRIP_CODE(LOW_TRIP_CODE),
    .POWER_LOOP_RANGING(POWER_LOOP_RANGING));

// ===== tb/lbq_laser_model.sv
// laser and power monitor model driven by the bias word
`timescale 1ns/1ps
module lbq_laser_model (
    input wire logic clk, // system clock
    input wire logic [8:0] bias, // bias word
    input wire logic ovr_en, // force the monitor code
    input wire logic [7:0] ovr_val, // forced monitor code
    output logic [7:0] mon // power monitor code
);
    // light grows with bias, one code per two bias steps
    always_ff @(posedge clk)
    begin
        mon <= ovr_en ? ovr_val : bias[8:1];
    end
endmodule : lbq_laser_model

// ===== tb/tb_lbq_bias_startup.sv
// bench for the bias startup and quick-trip block
`timescale 1ns/1ps
`include "lbq_defines.svh"
module tb_lbq_bias_startup;
    logic SYS_CLK = 1'b0;
    logic RST = 1'b1;
    logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TX_DISABLE, ovr_en, er;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rd;
    logic [7:0] TEMP_INDEX, POWER_SETPOINT_CODE, POWER_MONITOR_INPUT;
    logic [7:0] SIGNAL_STRENGTH, ovr_val, HIGH_TRIP_CODE, LOW_TRIP_CODE;
    logic [8:0] BIAS_WORD, v;
    logic [2:0] POWER_LOOP_RANGING;
    logic STARTUP_DONE, BIAS_MAX_ALARM, HIGH_POWER_ALARM, LOW_POWER_ALARM;
    logic SIGNAL_LOSS_LOW_ALARM, SIGNAL_LOSS_HIGH_ALARM;
    int n_errors = 0;
    int compares = 0;
    logic [7:0] reg_idx [7] = '{`LBQ_IDX_HOT_STEP, `LBQ_IDX_COLD_STEP,
        `LBQ_IDX_HI_OFS, `LBQ_IDX_LO_OFS, `LBQ_IDX_SIGNAL_LOSS_HIGH_ALARM, `LBQ_IDX_SIGNAL_LOSS_LOW_ALARM,
        `LBQ_IDX_CEILING};
    // index, ceiling, first step, settled bias
    logic [8:0] run_tab [4][4] = '{'{9'h81, 9'hff, 9'h1f, 9'h81},
        '{9'h80, 9'hff, 9'h1f, 9'h81}, '{9'h7f, 9'hff, 9'h0f, 9'h81},
        '{9'h7f, 9'h10, 9'h0f, 9'h21}};
    // setpoint, offsets, expected high and low codes
    logic [7:0] trip_tab [3][5] = '{'{8'hf0, 8'h20, 8'hf8, 8'hff, 8'h00},
        '{8'h10, 8'hef, 8'h10, 8'hff, 8'h00},
        '{8'h40, 8'h10, 8'h10, 8'h50, 8'h30}};
    // stimulus code, then the two expected alarm levels
    logic [7:0] pwr_tab [4][3] = '{'{8'h51, 8'h1, 8'h0},
        '{8'h50, 8'h0, 8'h0}, '{8'h30, 8'h0, 8'h0}, '{8'h2f, 8'h0, 8'h1}};
    logic [7:0] los_tab [5][3] = '{'{8'h20, 8'h1, 8'h0},
        '{8'h60, 8'h1, 8'h0}, '{8'h90, 8'h0, 8'h1}, '{8'h70, 8'h0, 8'h1},
        '{8'h20, 8'h1, 8'h0}};

    always #4 SYS_CLK = ~SYS_CLK;

    lbq_bias_startup dut_u (.SYS_CLK(SYS_CLK), .RST(RST), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .TEMP_INDEX(TEMP_INDEX), .POWER_SETPOINT_CODE(POWER_SETPOINT_CODE),
        .POWER_MONITOR_INPUT(POWER_MONITOR_INPUT),
        .SIGNAL_STRENGTH(SIGNAL_STRENGTH), .TX_DISABLE(TX_DISABLE),
        .BIAS_WORD(BIAS_WORD), .STARTUP_DONE(STARTUP_DONE),
        .BIAS_MAX_ALARM(BIAS_MAX_ALARM), .HIGH_POWER_ALARM(HIGH_POWER_ALARM),
        .LOW_POWER_ALARM(LOW_POWER_ALARM),
        .SIGNAL_LOSS_LOW_ALARM(SIGNAL_LOSS_LOW_ALARM),
        .SIGNAL_LOSS_HIGH_ALARM(SIGNAL_LOSS_HIGH_ALARM),
        .HIGH_TRIP_CODE(HIGH_TRIP_CODE), .LOW_TRIP_CODE(LOW_TRIP_CODE),
        .POWER_LOOP_RANGING(POWER_LOOP_RANGING));
    lbq_laser_model mdl_u (.clk(SYS_CLK), .bias(BIAS_WORD), .ovr_en(ovr_en),
        .ovr_val(ovr_val), .mon(POWER_MONITOR_INPUT));

    task chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task close_out;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task timed_out;
        n_errors++;
        close_out();
    endtask : timed_out

    task apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        int n;
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= ad;
        PWDATA <= wd;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        for (n = 0; n < 20 && PREADY !== 1'b1; n++)
            @(posedge SYS_CLK);
        if (PREADY !== 1'b1)
            timed_out();
        rd = PRDATA;
        er = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb

    task reg_io(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        apb(wr, {2'h0, idx, 2'h0}, wd);
    endtask : reg_io

    task wait_done(input logic lvl);
        int n;
        for (n = 0; n < 40000 && STARTUP_DONE !== lvl; n++)
            @(posedge SYS_CLK);
        if (STARTUP_DONE !== lvl)
            timed_out();
    endtask : wait_done

    task next_bias;
        int n;
        logic [8:0] old;
        old = BIAS_WORD;
        for (n = 0; n < 400 && BIAS_WORD === old; n++)
            @(posedge SYS_CLK);
        if (BIAS_WORD === old)
            timed_out();
        v = BIAS_WORD;
    endtask : next_bias

    initial
    begin
        int i;
        {PSEL, PENABLE, PWRITE, TX_DISABLE, ovr_en} = 5'h00;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        ovr_val = 8'h00;
        TEMP_INDEX = 8'h80;
        POWER_SETPOINT_CODE = 8'h40;
        SIGNAL_STRENGTH = 8'h00;
        repeat (10) @(posedge SYS_CLK);
        RST <= 1'b0;
        @(posedge SYS_CLK);
        chk("loss low", 32'h0, SIGNAL_LOSS_LOW_ALARM);
        chk("loss high", 32'h0, SIGNAL_LOSS_HIGH_ALARM);
        chk("ranging", 32'h0, POWER_LOOP_RANGING);
        for (i = 0; i < 7; i++)
        begin
            reg_io(1'b0, reg_idx[i], 32'h0);
            chk("reset value", (i == 6) ? 32'hff : 32'h0, rd);
            reg_io(1'b1, reg_idx[i], 32'hffffff00 | i * 17);
            reg_io(1'b0, reg_idx[i], 32'h0);
            chk("read back", i * 17, rd);
        end
        reg_io(1'b1, `LBQ_IDX_RANGING, 32'hfffffffd);
        repeat (2) @(posedge SYS_CLK);
        chk("ranging", 32'h5, POWER_LOOP_RANGING);
        apb(1'b0, 12'h000, 32'h0);
        chk("unmapped error", 32'h1, er);
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, {2'h0, `LBQ_IDX_HOT_STEP, 2'h1}, 32'h0);
        chk("unaligned error", 32'h1, er);
        reg_io(1'b1, `LBQ_IDX_HOT_STEP, 32'h0f);
        reg_io(1'b1, `LBQ_IDX_COLD_STEP, 32'h07);
        reg_io(1'b1, `LBQ_IDX_STEP_TI, 32'h80);
        reg_io(1'b1, `LBQ_IDX_CEILING, 32'hff);
        reg_io(1'b1, `LBQ_IDX_SIGNAL_LOSS_LOW_ALARM, 32'h30);
        reg_io(1'b1, `LBQ_IDX_SIGNAL_LOSS_HIGH_ALARM, 32'h80);
        wait_done(1'b1);
        $display("test registers done");
        for (i = 0; i < 4; i++)
        begin
            reg_io(1'b1, `LBQ_IDX_CEILING, {24'h0, run_tab[i][1][7:0]});
            TEMP_INDEX <= run_tab[i][0][7:0];
            TX_DISABLE <= 1'b1;
            repeat (10) @(posedge SYS_CLK);
            TX_DISABLE <= 1'b0;
            wait_done(1'b0);
            next_bias();
            if (v === 9'h000)
                next_bias();
            chk("first step", run_tab[i][2], v);
            next_bias();
            chk("second step", run_tab[i][2] * 2, v);
            wait_done(1'b1);
            repeat (2) @(posedge SYS_CLK);
            chk("settled bias", run_tab[i][3], BIAS_WORD);
            chk("bias max", 32'h0, BIAS_MAX_ALARM);
        end
        reg_io(1'b1, `LBQ_IDX_CEILING, 32'h08);
        repeat (3) @(posedge SYS_CLK);
        chk("bias max", 32'h1, BIAS_MAX_ALARM);
        // status: bias 0x21, done, bias max, loss low
        reg_io(1'b0, `LBQ_IDX_STATUS, 32'h0);
        chk("status", 32'h2621, rd);
        reg_io(1'b0, `LBQ_IDX_SETPOINT, 32'h0);
        chk("setpoint", 32'h40, rd);
        $display("test startup done");
        for (i = 0; i < 3; i++)
        begin
            POWER_SETPOINT_CODE <= trip_tab[i][0];
            reg_io(1'b1, `LBQ_IDX_HI_OFS, trip_tab[i][1]);
            reg_io(1'b1, `LBQ_IDX_LO_OFS, trip_tab[i][2]);
            repeat (3) @(posedge SYS_CLK);
            chk("high code", trip_tab[i][3], HIGH_TRIP_CODE);
            chk("low code", trip_tab[i][4], LOW_TRIP_CODE);
        end
        ovr_en <= 1'b1;
        for (i = 0; i < 4; i++)
        begin
            ovr_val <= pwr_tab[i][0];
            repeat (10) @(posedge SYS_CLK);
            chk("power high", pwr_tab[i][1], HIGH_POWER_ALARM);
            chk("power low", pwr_tab[i][2], LOW_POWER_ALARM);
        end
        for (i = 0; i < 5; i++)
        begin
            SIGNAL_STRENGTH <= los_tab[i][0];
            repeat (10) @(posedge SYS_CLK);
            chk("loss low", los_tab[i][1], SIGNAL_LOSS_LOW_ALARM);
            chk("loss high", los_tab[i][2], SIGNAL_LOSS_HIGH_ALARM);
        end
        $display("test quick trip done");
        close_out();
    end
endmodule : tb_lbq_bias_startup
